// File: hdl/arb_pkg.sv
// Package: constants and types of the result read-back serial interface
// Overview of operation
// - Four read-back modes from two control bits at address 3; mode 0 after reset.
// - Mode 0 sends nothing by itself; each result needs an explicit read instruction.
// - Mode 0: 16-bit read at 1 MS first, at 0 LS first, 8-bit at 1 MS only.
// - A read returns the last result completed before the data word's first active edge.
// - Mode 1 arms an implied 16-bit read of address 1 on a serial start.
// - Automatic modes return the last completed result at the sampling edge.
// - Mode 2 returns the result LS byte first, as a 16-bit read of address 0.
// - Mode 3 returns only the MS byte, as an 8-bit read of address 1.
// - Mode 3 never shortens the conversion; full conversions still run.
// - Only serial starts arm automatic read-back; the convert pin never does.
// - First output bit loads on the first active edge; the rest on inactive edges.
// - Serial output is not valid before the read's first active edge.
// - Each transfer is a write or a read, never full duplex.
// - A serial start begins on the second divided-clock falling edge after the eighth edge.
// - Busy stays low for the first divided-clock period, then high until conversion end.
// - Two-wire mode drives read data on the data-in pin as well as data-out.
// - Early release floats data-in on the last active edge of the final byte.
package arb_pkg;

	localparam int SYS_CLK_MHZ = 25;
	localparam int CORE_CONV_CLOCK_PERIOD_NS = 400;
	localparam int CORE_CONV_CLOCK_CYCLES = (CORE_CONV_CLOCK_PERIOD_NS * SYS_CLK_MHZ) / 1000;
	localparam logic [7:0] PRESC_LAST = 8'(CORE_CONV_CLOCK_CYCLES - 1);
	localparam int CONV_DIVIDED_CONV_CLOCK_PERIODS = 16;
	localparam logic [4:0] CONV_LAST = 5'(CONV_DIVIDED_CONV_CLOCK_PERIODS - 1);

	localparam int RESULT_W = 16;
	localparam logic [4:0] ADDR_RES_LO = 5'h00;
	localparam logic [4:0] ADDR_RES_HI = 5'h01;
	localparam logic [4:0] ADDR_INTF_CFG = 5'h02;
	localparam logic [4:0] ADDR_CTRL = 5'h03;
	localparam logic [4:0] ADDR_GAIN_MUX = 5'h04;
	localparam logic [4:0] ADDR_PAIR_FLIP = 5'h01;

	localparam int INS_CONV_BIT = 7;
	localparam int INS_READ_BIT = 6;
	localparam int INS_WORD_BIT = 5;
	localparam int INS_ADDR_HI = 4;

	localparam int CTRL_DIV_LO_BIT = 0;
	localparam int CTRL_DIV_HI_BIT = 1;
	localparam int CTRL_RBM_LO_BIT = 2;
	localparam int CTRL_RBM_HI_BIT = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	localparam int CFG_EARLY_BIT = 0;
	localparam int CFG_LSB_BIT = 1;
	localparam int CFG_SHARED_BIT = 2;
	localparam logic [7:0] CFG_RESET = 8'h00;

	localparam int GAIN_CONV_BIT = 7;
	localparam logic [7:0] GAIN_RESET = 8'h00;
	localparam logic [15:0] RESULT_RESET = 16'h0000;

	localparam logic [4:0] BYTE_LAST = 5'h07;
	localparam logic [4:0] WORD_LAST = 5'h0f;
	localparam logic [4:0] SYNC_RESET = 5'h02;

	typedef enum logic [1:0] {
		RB_MANUAL = 2'h0,
		RB_AUTO_MSB = 2'h1,
		RB_AUTO_LSB = 2'h2,
		RB_AUTO_MSONLY = 2'h3
	} arb_rbm_type;

	typedef enum logic [1:0] {
		SP_IDLE = 2'h0,
		SP_INSTR = 2'h1,
		SP_READ = 2'h3,
		SP_WRITE = 2'h2
	} arb_sp_type;

	typedef enum logic [1:0] {
		CV_IDLE = 2'h0,
		CV_WAIT = 2'h1,
		CV_RUN = 2'h3,
		CV_DONE = 2'h2
	} arb_cv_type;

endpackage : arb_pkg

// File: hdl/arb_pair_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module arb_pair_buf
	import arb_pkg::*;
#(
	parameter int WIDTH = RESULT_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	logic [WIDTH-1:0] slot_r [2];
	logic wp_r;
	logic rp_r;
	logic [1:0] cnt_r;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	assign in_ready = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data = slot_r[rp_r];

	always_ff @(posedge clk) begin
		if (push) begin
			slot_r[wp_r] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			wp_r <= wp_r ^ push;
			rp_r <= rp_r ^ pop;
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule : arb_pair_buf

// File: hdl/arb_readback_serial.sv
// Serial result read-back interface with conversion sequencer
`timescale 1ns/1ns
module arb_readback_serial
	import arb_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic RISE_FALL,
	input wire logic DIN,
	input wire logic CONVERT,
	input wire logic [15:0] RESULT_IN,
	output logic DOUT,
	output logic DOUT_OE_N,
	output logic DIN_OUT,
	output logic DIN_OE_N,
	output logic BUSY
);

	// Pin synchronisers
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic sclk_q_r;
	logic conv_q_r;
	wire [4:0] pin_vec = {CONVERT, DIN, RISE_FALL, CS_N, SCLK};

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			sync1_r <= SYNC_RESET;
			sync2_r <= SYNC_RESET;
			sclk_q_r <= 1'b0;
			conv_q_r <= 1'b0;
		end else begin
			sync1_r <= pin_vec;
			sync2_r <= sync1_r;
			sclk_q_r <= sync2_r[0];
			conv_q_r <= sync2_r[4];
		end
	end

	wire sclk_s = sync2_r[0];
	wire cs_active = ~sync2_r[1];
	wire rise_act = sync2_r[2];
	wire din_s = sync2_r[3];
	wire sclk_rise = sclk_s & ~sclk_q_r;
	wire sclk_fall = ~sclk_s & sclk_q_r;
	wire act_edge = rise_act ? sclk_rise : sclk_fall;
	wire inact_edge = rise_act ? sclk_fall : sclk_rise;
	wire conv_edge = sync2_r[4] & ~conv_q_r;

	// Register file
	logic [7:0] ctrl_r;
	logic [7:0] cfg_r;
	logic [7:0] gain_r;
	logic [15:0] result_r;

	arb_rbm_type mode;
	assign mode = arb_rbm_type'(ctrl_r[CTRL_RBM_HI_BIT:CTRL_RBM_LO_BIT]);
	wire [1:0] div_sel = ctrl_r[CTRL_DIV_HI_BIT:CTRL_DIV_LO_BIT];
	wire lsb_first = cfg_r[CFG_LSB_BIT];
	wire shared_data_line_sel = cfg_r[CFG_SHARED_BIT];
	wire early_rel = cfg_r[CFG_EARLY_BIT];
	wire auto_mode = (mode != RB_MANUAL);

	function automatic logic [7:0] rev8(input logic [7:0] b);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7 - i];
		end
		return r;
	endfunction : rev8

	function automatic logic [7:0] reg_rd(input logic [4:0] a, input logic [15:0] res,
			input logic [7:0] cfg, input logic [7:0] ctl, input logic [7:0] gm);
		logic [7:0] v;
		v = 8'h00;
		if (a == ADDR_RES_LO) begin
			v = res[7:0];
		end else if (a == ADDR_RES_HI) begin
			v = res[15:8];
		end else if (a == ADDR_INTF_CFG) begin
			v = cfg;
		end else if (a == ADDR_CTRL) begin
			v = ctl;
		end else if (a == ADDR_GAIN_MUX) begin
			v = gm;
		end
		return v;
	endfunction : reg_rd

	// Serial engine state
	arb_sp_type sp_r;
	arb_sp_type sp_nxt;
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic [4:0] addr_r;
	logic [4:0] addr_nxt;
	logic word_r;
	logic word_nxt;
	logic [7:0] rx_r;
	logic [15:0] tx_r;
	logic [15:0] tx_nxt;
	logic bit_r;
	logic bit_nxt;
	logic en_r;
	logic en_nxt;
	logic hold_r;
	logic hold_nxt;
	logic oe_n_r;
	logic din_oe_n_r;
	logic wr_en;
	logic ser_start;

	wire [7:0] rx_nxt = lsb_first ? {din_s, rx_r[7:1]} : {rx_r[6:0], din_s};
	wire byte_done = act_edge & (cnt_r[2:0] == 3'h7);
	wire [4:0] last_cnt = word_r ? WORD_LAST : BYTE_LAST;

	// Implied read of an automatic mode
	wire [4:0] auto_addr = (mode == RB_AUTO_LSB) ? ADDR_RES_LO : ADDR_RES_HI;
	wire auto_word = (mode != RB_AUTO_MSONLY);

	// Read word, taken whole at the first active edge of the data word
	wire [7:0] byte_a = reg_rd(addr_r, result_r, cfg_r, ctrl_r, gain_r);
	wire [7:0] byte_b = reg_rd(addr_r ^ ADDR_PAIR_FLIP, result_r, cfg_r, ctrl_r, gain_r);
	wire [15:0] word_raw = word_r ? {byte_a, byte_b} : {byte_a, 8'h00};
	wire [15:0] rd_word = lsb_first ? {rev8(word_raw[15:8]), rev8(word_raw[7:0])} : word_raw;

	// Register write decode
	wire [4:0] wr_addr = (word_r && cnt_r[3]) ? (addr_r ^ ADDR_PAIR_FLIP) : addr_r;
	wire wr_ctrl = wr_en && (wr_addr == ADDR_CTRL);
	wire wr_cfg = wr_en && (wr_addr == ADDR_INTF_CFG);
	wire wr_gain = wr_en && (wr_addr == ADDR_GAIN_MUX);
	wire wr_conv = wr_gain && rx_nxt[GAIN_CONV_BIT];

	always_comb begin
		sp_nxt = sp_r;
		cnt_nxt = cnt_r;
		addr_nxt = addr_r;
		word_nxt = word_r;
		tx_nxt = tx_r;
		bit_nxt = bit_r;
		en_nxt = en_r;
		hold_nxt = hold_r;
		wr_en = 1'b0;
		ser_start = 1'b0;
		if (!cs_active) begin
			sp_nxt = SP_IDLE;
			cnt_nxt = 5'h00;
			en_nxt = 1'b0;
			hold_nxt = 1'b0;
		end else begin
			if (hold_r && inact_edge) begin
				en_nxt = 1'b0;
				hold_nxt = 1'b0;
			end
			unique case (sp_r)
				SP_IDLE: begin
					sp_nxt = SP_INSTR;
					cnt_nxt = 5'h00;
				end
				SP_INSTR: begin
					if (act_edge) begin
						cnt_nxt = cnt_r + 5'h01;
					end
					if (byte_done) begin
						cnt_nxt = 5'h00;
						addr_nxt = rx_nxt[INS_ADDR_HI:0];
						word_nxt = rx_nxt[INS_WORD_BIT];
						if (rx_nxt[INS_CONV_BIT]) begin
							ser_start = 1'b1;
							sp_nxt = auto_mode ? SP_READ : SP_INSTR;
							if (auto_mode) begin
								addr_nxt = auto_addr;
								word_nxt = auto_word;
							end
						end else if (rx_nxt[INS_READ_BIT]) begin
							sp_nxt = SP_READ;
						end else begin
							sp_nxt = SP_WRITE;
						end
					end
				end
				SP_READ: begin
					if (act_edge) begin
						cnt_nxt = cnt_r + 5'h01;
						if (cnt_r == 5'h00) begin
							tx_nxt = {rd_word[14:0], 1'b0};
							bit_nxt = rd_word[15];
							en_nxt = 1'b1;
						end
						if (cnt_r == last_cnt) begin
							sp_nxt = SP_INSTR;
							cnt_nxt = 5'h00;
							en_nxt = early_rel ? 1'b0 : en_nxt;
							hold_nxt = ~early_rel;
						end
					end else if (inact_edge && (cnt_r != 5'h00)) begin
						bit_nxt = tx_r[15];
						tx_nxt = {tx_r[14:0], 1'b0};
					end
				end
				SP_WRITE: begin
					en_nxt = 1'b0;
					if (act_edge) begin
						cnt_nxt = cnt_r + 5'h01;
					end
					if (byte_done) begin
						wr_en = 1'b1;
						ser_start = wr_conv;
						if (!word_r || cnt_r[3]) begin
							cnt_nxt = 5'h00;
							sp_nxt = (wr_conv && auto_mode) ? SP_READ : SP_INSTR;
							if (wr_conv && auto_mode) begin
								addr_nxt = auto_addr;
								word_nxt = auto_word;
							end
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			sp_r <= SP_IDLE;
			cnt_r <= 5'h00;
			addr_r <= 5'h00;
			word_r <= 1'b0;
			rx_r <= 8'h00;
			tx_r <= 16'h0000;
			bit_r <= 1'b0;
			en_r <= 1'b0;
			hold_r <= 1'b0;
			oe_n_r <= 1'b1;
			din_oe_n_r <= 1'b1;
		end else begin
			sp_r <= sp_nxt;
			cnt_r <= cnt_nxt;
			addr_r <= addr_nxt;
			word_r <= word_nxt;
			rx_r <= act_edge ? rx_nxt : rx_r;
			tx_r <= tx_nxt;
			bit_r <= bit_nxt;
			en_r <= en_nxt;
			hold_r <= hold_nxt;
			oe_n_r <= ~en_nxt;
			din_oe_n_r <= ~(en_nxt & shared_data_line_sel);
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_r <= CTRL_RESET;
			cfg_r <= CFG_RESET;
			gain_r <= GAIN_RESET;
		end else begin
			ctrl_r <= wr_ctrl ? rx_nxt : ctrl_r;
			cfg_r <= wr_cfg ? rx_nxt : cfg_r;
			gain_r <= wr_gain ? rx_nxt : gain_r;
		end
	end

	// Completed results pass a two-entry buffer into the result pair
	logic buf_in_ready;
	logic buf_out_valid;
	logic [15:0] buf_out_data;
	arb_cv_type cv_r;
	wire buf_in_valid = (cv_r == CV_DONE);
	wire res_ready = ~((sp_r == SP_READ) && (cnt_r != 5'h00));

	arb_pair_buf #(
		.WIDTH(RESULT_W)
	) u_res_buf (
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(RESULT_IN),
		.out_valid(buf_out_valid),
		.out_ready(res_ready),
		.out_data(buf_out_data)
	);

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			result_r <= RESULT_RESET;
		end else if (buf_out_valid && res_ready) begin
			result_r <= buf_out_data;
		end
	end

	// Conversion clocks
	logic [7:0] presc_r;
	logic [2:0] dcnt_r;
	wire core_conv_clock_tick = (presc_r == PRESC_LAST);
	wire [2:0] div_mask = {div_sel == 2'h3, div_sel[1], div_sel != 2'h0};
	wire divided_conv_clock_tick = core_conv_clock_tick && ((dcnt_r & div_mask) == div_mask);

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			presc_r <= 8'h00;
			dcnt_r <= 3'h0;
		end else begin
			presc_r <= core_conv_clock_tick ? 8'h00 : presc_r + 8'h01;
			dcnt_r <= divided_conv_clock_tick ? 3'h0 : (core_conv_clock_tick ? dcnt_r + 3'h1 : dcnt_r);
		end
	end

	// Conversion sequencer
	arb_cv_type cv_nxt;
	logic wcnt_r;
	logic wcnt_nxt;
	logic [4:0] pcnt_r;
	logic [4:0] pcnt_nxt;
	logic busy_r;
	logic busy_nxt;
	logic queue_r;
	logic queue_nxt;
	logic pin_wait_r;
	logic pin_wait_nxt;
	wire wait_tick = pin_wait_r ? core_conv_clock_tick : divided_conv_clock_tick;

	always_comb begin
		cv_nxt = cv_r;
		wcnt_nxt = wcnt_r;
		pcnt_nxt = pcnt_r;
		busy_nxt = busy_r;
		queue_nxt = queue_r;
		pin_wait_nxt = pin_wait_r;
		if (ser_start && ((cv_r == CV_RUN) || (cv_r == CV_DONE))) begin
			queue_nxt = 1'b1;
		end
		unique case (cv_r)
			CV_IDLE: begin
				if (ser_start) begin
					cv_nxt = CV_WAIT;
					wcnt_nxt = 1'b0;
					pin_wait_nxt = 1'b0;
				end
			end
			CV_WAIT: begin
				if (wait_tick) begin
					wcnt_nxt = 1'b1;
					cv_nxt = wcnt_r ? CV_RUN : CV_WAIT;
					pcnt_nxt = 5'h00;
				end
			end
			CV_RUN: begin
				if (divided_conv_clock_tick) begin
					busy_nxt = 1'b1;
					pcnt_nxt = pcnt_r + 5'h01;
					cv_nxt = (pcnt_r == CONV_LAST) ? CV_DONE : CV_RUN;
				end
			end
			CV_DONE: begin
				if (buf_in_ready) begin
					busy_nxt = 1'b0;
					cv_nxt = queue_r ? CV_RUN : CV_IDLE;
					pcnt_nxt = 5'h00;
					queue_nxt = 1'b0;
				end
			end
		endcase
		if (conv_edge) begin
			cv_nxt = CV_WAIT;
			wcnt_nxt = 1'b0;
			pin_wait_nxt = 1'b1;
			busy_nxt = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			cv_r <= CV_IDLE;
			wcnt_r <= 1'b0;
			pcnt_r <= 5'h00;
			busy_r <= 1'b0;
			queue_r <= 1'b0;
			pin_wait_r <= 1'b0;
		end else begin
			cv_r <= cv_nxt;
			wcnt_r <= wcnt_nxt;
			pcnt_r <= pcnt_nxt;
			busy_r <= busy_nxt;
			queue_r <= queue_nxt;
			pin_wait_r <= pin_wait_nxt;
		end
	end

	assign DOUT = bit_r;
	assign DIN_OUT = bit_r;
	assign DOUT_OE_N = oe_n_r;
	assign DIN_OE_N = din_oe_n_r;
	assign BUSY = busy_r;

endmodule : arb_readback_serial

// File: bench/arb_readback_serial_assertions.sv
// Checker of the serial read-back port behaviour
`timescale 1ns/1ns
module arb_readback_serial_assertions(
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic RISE_FALL,
	input wire logic DOUT,
	input wire logic DOUT_OE_N,
	input wire logic DIN_OUT,
	input wire logic DIN_OE_N,
	input wire logic BUSY
);
	logic [9:0] busy_cnt_r;
	logic [9:0] busy_cnt_nxt;
	assign busy_cnt_nxt = BUSY ? busy_cnt_r + 10'h001 : 10'h000;
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) busy_cnt_r <= 10'h000;
		else busy_cnt_r <= busy_cnt_nxt;
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	property p_reset_idle;
		$rose(RSTN) |-> DOUT_OE_N && DIN_OE_N && !BUSY;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
	property p_busy_len;
		$fell(BUSY) |-> busy_cnt_r inside {[10'd145:10'd155]};
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_dout_hold;
		(!DOUT_OE_N && $stable(SCLK)) [*6] |-> $stable(DOUT);
	endproperty
	a_dout_hold: assert property (p_dout_hold) else $error("data moved without edge");
	property p_oe_on_active;
		$fell(DOUT_OE_N) |-> SCLK == RISE_FALL && $past(SCLK, 2) == RISE_FALL;
	endproperty
	a_oe_on_active: assert property (p_oe_on_active) else $error("drive began off edge");
	property p_oe_after_cs;
		$fell(DOUT_OE_N) |-> !CS_N && $past(CS_N, 8) == 1'b0;
	endproperty
	a_oe_after_cs: assert property (p_oe_after_cs) else $error("drive before word");
	property p_cs_release;
		CS_N [*6] |-> DOUT_OE_N && DIN_OE_N;
	endproperty
	a_cs_release: assert property (p_cs_release) else $error("driving while idle");
	property p_din_mirror;
		!DIN_OE_N |-> !DOUT_OE_N && DIN_OUT == DOUT;
	endproperty
	a_din_mirror: assert property (p_din_mirror) else $error("shared line differs");
	property p_early;
		$rose(DIN_OE_N) && !CS_N |-> SCLK == RISE_FALL;
	endproperty
	a_early: assert property (p_early) else $error("late release of data-in");
	c_busy: cover property ($rose(BUSY));
	c_read: cover property ($fell(DOUT_OE_N));
	c_shared: cover property ($fell(DIN_OE_N));
endmodule : arb_readback_serial_assertions
bind arb_readback_serial arb_readback_serial_assertions chk_u(.SYS_CLK(SYS_CLK), .RSTN(RSTN),
	.SCLK(SCLK), .CS_N(CS_N), .RISE_FALL(RISE_FALL), .DOUT(DOUT), .DOUT_OE_N(DOUT_OE_N),
	.DIN_OUT(DIN_OUT), .DIN_OE_N(DIN_OE_N), .BUSY(BUSY));

// File: bench/arb_host_model.sv
// Host serial master model: frames, bytes out, words in
`timescale 1ns/1ns
module arb_host_model(
	input wire logic clk,
	input wire logic dout,
	output logic sclk,
	output logic cs_n,
	output logic din,
	output logic rd_valid,
	output logic [15:0] rd_data
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
		rd_valid = 1'b0;
		rd_data = 16'h0000;
	end
	task automatic half();
		repeat (8) @(negedge clk);
	endtask : half
	// Clock stands still outside frames
	task automatic select(input logic lvl);
		cs_n = lvl;
		din = ~din;
		half();
	endtask : select
	// Byte out, MSB first, rising edge active; nothing sampled meanwhile
	task automatic put(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			din = b[i];
			half();
			sclk = 1'b1;
			half();
			sclk = 1'b0;
		end
	endtask : put
	// Word in, sampled before each inactive edge; own data line toggles
	task automatic get(input int n);
		rd_data = 16'h0000;
		for (int i = 0; i < n; i++) begin
			din = ~din;
			half();
			sclk = 1'b1;
			half();
			rd_data = {rd_data[14:0], dout};
			sclk = 1'b0;
		end
		rd_valid = 1'b1;
		@(negedge clk);
		rd_valid = 1'b0;
	endtask : get
endmodule : arb_host_model

// File: bench/testbench.sv
// Self-checking testbench of the serial read-back interface
`timescale 1ns/1ns
module testbench
	import arb_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic convert = 1'b0;
	logic rise_fall = 1'b1;
	logic [15:0] result_in = 16'h0000;
	logic [15:0] done_res = RESULT_RESET;
	logic [15:0] rd_data;
	logic [15:0] exp_q[$];
	logic sclk, cs_n, host_din, din_line, dout, dout_oe_n, din_out, din_oe_n, busy, rd_valid;
	int err_count = 0;
	int n_checks = 0;
	assign din_line = din_oe_n ? host_din : din_out;
	// Released data-out line floats to its pull-up level
	wire host_dout = dout_oe_n ? 1'b1 : dout;
	always #20 sys_clk = ~sys_clk;
	arb_readback_serial dut_u(.SYS_CLK(sys_clk), .RSTN(rstn), .SCLK(sclk), .CS_N(cs_n),
		.RISE_FALL(rise_fall), .DIN(din_line), .CONVERT(convert), .RESULT_IN(result_in),
		.DOUT(dout), .DOUT_OE_N(dout_oe_n), .DIN_OUT(din_out), .DIN_OE_N(din_oe_n), .BUSY(busy));
	arb_host_model host_u(.clk(sys_clk), .dout(host_dout), .sclk(sclk), .cs_n(cs_n), .din(host_din),
		.rd_valid(rd_valid), .rd_data(rd_data));
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test
	always @(posedge rd_valid) cmp("read word", exp_q.pop_front(), rd_data);
	// Instruction 8'h00 stands for an implied read with no instruction byte
	task automatic rd(input logic [7:0] ins, input int n, input logic [15:0] exp);
		exp_q.push_back(exp);
		if (ins != 8'h00) host_u.put(ins);
		host_u.get(n);
	endtask : rd
	task automatic start();
		result_in = 16'($urandom);
		host_u.put(8'h80);
	endtask : start
	// Chip select stays low while waiting for busy to fall
	task automatic wait_done();
		int k;
		k = 0;
		while (busy !== 1'b1 && k < 400) begin
			@(negedge sys_clk);
			k++;
		end
		while (busy !== 1'b0 && k < 800) begin
			@(negedge sys_clk);
			k++;
		end
		cmp("busy", 16'h0000, {15'h0, busy});
		repeat (4) @(negedge sys_clk);
		done_res = result_in;
	endtask : wait_done
	initial begin
		void'($urandom(32'h66538baa));
		repeat (10) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (4) @(negedge sys_clk);
		cmp("idle enables", 16'h0003, {14'h0, dout_oe_n, din_oe_n});
		host_u.select(1'b0);
		rd(8'h43, 8, 16'h0000);
		rd(8'h45, 8, 16'h0000);
		start();
		rd(8'h61, 16, done_res);
		wait_done();
		rd(8'h61, 16, done_res);
		rd(8'h60, 16, {done_res[7:0], done_res[15:8]});
		rd(8'h41, 8, {8'h00, done_res[15:8]});
		$display("test manual mode done");
		for (int m = 1; m < 4; m++) begin
			host_u.put(8'h03);
			host_u.put(8'(m << 2));
			rd(8'h43, 8, {8'h00, 8'(m << 2)});
			start();
			case (m)
				1: rd(8'h00, 16, done_res);
				2: rd(8'h00, 16, {done_res[7:0], done_res[15:8]});
				default: rd(8'h00, 8, {8'h00, done_res[15:8]});
			endcase
			wait_done();
			rd(8'h61, 16, done_res);
			$display("test automatic mode %0d done", m);
		end
		// Chip select stays low so that a wrongly armed automatic read would show
		result_in = 16'($urandom);
		convert = 1'b1;
		repeat (60) @(negedge sys_clk);
		convert = 1'b0;
		wait_done();
		cmp("pin start quiet", 16'h0001, {15'h0, dout_oe_n});
		rd(8'h61, 16, done_res);
		$display("test pin start done");
		host_u.put(8'h02);
		host_u.put(8'h05);
		rd(8'h61, 16, done_res);
		cmp("data-in released", 16'h0001, {15'h0, din_oe_n});
		host_u.select(1'b1);
		$display("test shared line done");
		end_of_test();
	end
	initial begin
		repeat (60000) @(posedge sys_clk);
		err_count++;
		end_of_test();
	end
endmodule : testbench
